// [tsk_key.sv]
// timed secure key: three-wire serial command engine, secure memory and day countdown
`include "tsk_defines.svh"

module tsk_key #(
  parameter int unsigned OSC_TICK_CYCLES = `TSK_OSC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // three-wire link pins
  input wire logic link_rst_pin,
  input wire logic link_sclk_pin,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  // status
  output logic days_expired,
  output logic days_locked,
  output logic osc_armed,
  output logic osc_running
);

  logic [`TSK_PIN_W-1:0] pins_s;
  logic sclk_rise;
  logic sclk_fall;
  logic link_rst_s;
  logic dq_s;

  tsk_pkg::tsk_state_t state_reg;
  tsk_pkg::tsk_state_t phase_next;
  logic [`TSK_CNT_W-1:0] cnt_reg;
  logic [`TSK_CNT_W-1:0] phase_last;
  logic [`TSK_CMD_W-1:0] cmd_reg;
  logic [`TSK_CMD_W-1:0] cmd_next;
  logic cmd_done;
  logic is_write_reg;
  logic [`TSK_ID_W-1:0] cmp_reg;
  logic match_now;
  logic [`TSK_ID_W-1:0] id_reg;
  logic [`TSK_ID_W-1:0] match_reg;
  logic [`TSK_MEM_W-1:0] secure_reg;
  logic [`TSK_DAYS_W-1:0] days_reg;
  logic [`TSK_DAYS_W-1:0] days_sh_reg;
  logic [`TSK_DAYS_W-1:0] days_rd;
  logic expired_reg;
  logic lock_reg;
  logic arm_reg;
  logic osc_run_reg;
  logic [`TSK_CLK_W-1:0] day_cnt;
  logic [`TSK_CLK_W-1:0] clk_snap_reg;
  logic day_wrap;
  logic [15:0] lfsr_reg;
  logic dq_out_reg;
  logic dq_oe_reg;
  logic out_phase;
  logic out_bit;

  // command word framing: pattern of bytes two and three
  function automatic logic frame_ok(input logic [`TSK_CMD_W-1:0] c, input logic [1:0] mode);
    frame_ok = (c[`TSK_MODE_HI:`TSK_MODE_LO] == mode) &&
               (c[`TSK_PAD_HI:`TSK_PAD_LO] == `TSK_PAD_VAL) &&
               (c[`TSK_TAIL_HI:`TSK_TAIL_LO] == `TSK_TAIL_VAL);
  endfunction

  // exact program mode command with a given function code
  function automatic logic prog_hit(input logic [`TSK_CMD_W-1:0] c, input logic [7:0] fn);
    prog_hit = frame_ok(c, `TSK_MODE_PROG) && (c[`TSK_FN_HI:`TSK_FN_LO] == fn);
  endfunction

  // exact normal mode command with a given function code
  function automatic logic norm_hit(input logic [`TSK_CMD_W-1:0] c, input logic [7:0] fn);
    norm_hit = frame_ok(c, `TSK_MODE_NORM) && (c[`TSK_FN_HI:`TSK_FN_LO] == fn);
  endfunction

  // any of the nine accepted command words
  function automatic logic cmd_ok(input logic [`TSK_CMD_W-1:0] c);
    cmd_ok = norm_hit(c, `TSK_FN_NREAD) || norm_hit(c, `TSK_FN_NWRITE) ||
             prog_hit(c, `TSK_FN_PID) || prog_hit(c, `TSK_FN_RDCLK) ||
             prog_hit(c, `TSK_FN_WRDAYS) || prog_hit(c, `TSK_FN_RDDAYS) ||
             prog_hit(c, `TSK_FN_STOP) || prog_hit(c, `TSK_FN_ARM) ||
             prog_hit(c, `TSK_FN_LOCK);
  endfunction

  // phase that follows a complete command word
  function automatic tsk_pkg::tsk_state_t cmd_decode(input logic [`TSK_CMD_W-1:0] c,
                                                      input logic expired,
                                                      input logic locked);
    cmd_decode = tsk_pkg::TSK_ST_DONE;
    if (norm_hit(c, `TSK_FN_NREAD) || norm_hit(c, `TSK_FN_NWRITE)) begin
      cmd_decode = tsk_pkg::TSK_ST_ID_OUT;
    end else if (prog_hit(c, `TSK_FN_PID) && !expired) begin
      cmd_decode = tsk_pkg::TSK_ST_PID_IN;
    end else if (prog_hit(c, `TSK_FN_RDCLK)) begin
      cmd_decode = tsk_pkg::TSK_ST_CLK_OUT;
    end else if (prog_hit(c, `TSK_FN_RDDAYS)) begin
      cmd_decode = tsk_pkg::TSK_ST_DAYS_OUT;
    end else if (prog_hit(c, `TSK_FN_WRDAYS) && !locked && !expired) begin
      cmd_decode = tsk_pkg::TSK_ST_DAYS_IN;
    end
  endfunction

  // pin synchronisers and serial clock edges
  tsk_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins_in({dq_in, link_sclk_pin, link_rst_pin}),
    .pins_sync(pins_s),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  assign link_rst_s = pins_s[`TSK_PIN_RST];
  assign dq_s = pins_s[`TSK_PIN_DQ];

  // day clock from internal oscillator
  tsk_day_clock #(
    .TICK_CYCLES(OSC_TICK_CYCLES)
  ) u_day_clock (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(osc_run_reg),
    .count(day_cnt),
    .wrap(day_wrap)
  );

  assign cmd_next = {dq_s, cmd_reg[`TSK_CMD_W-1:1]};
  assign cmd_done = sclk_rise && (state_reg == tsk_pkg::TSK_ST_CMD) &&
                    (cnt_reg == `TSK_CMD_LAST);
  assign match_now = ({dq_s, cmp_reg[`TSK_ID_W-1:1]} == match_reg);
  assign days_rd = expired_reg ? `TSK_DAYS_EXPIRED : days_reg;

  // length and successor of the current phase
  always_comb begin
    phase_last = `TSK_CMD_LAST;
    phase_next = tsk_pkg::TSK_ST_DONE;
    unique case (state_reg)
      tsk_pkg::TSK_ST_IDLE: phase_next = tsk_pkg::TSK_ST_CMD;
      tsk_pkg::TSK_ST_CMD: phase_next = cmd_decode(cmd_next, expired_reg, lock_reg);
      tsk_pkg::TSK_ST_ID_OUT: begin
        phase_last = `TSK_ID_LAST;
        phase_next = tsk_pkg::TSK_ST_MATCH_IN;
      end
      tsk_pkg::TSK_ST_MATCH_IN: begin
        phase_last = `TSK_ID_LAST;
        if (is_write_reg) begin
          phase_next = (match_now && !expired_reg) ? tsk_pkg::TSK_ST_MEM_IN :
                       tsk_pkg::TSK_ST_DONE;
        end else begin
          phase_next = match_now ? tsk_pkg::TSK_ST_MEM_OUT :
                       tsk_pkg::TSK_ST_GARBLE;
        end
      end
      tsk_pkg::TSK_ST_MEM_OUT: phase_last = `TSK_MEM_LAST;
      tsk_pkg::TSK_ST_MEM_IN: phase_last = `TSK_MEM_LAST;
      tsk_pkg::TSK_ST_GARBLE: phase_last = `TSK_MEM_LAST;
      tsk_pkg::TSK_ST_PID_IN: phase_last = `TSK_PID_LAST;
      tsk_pkg::TSK_ST_CLK_OUT: phase_last = `TSK_CLK_LAST;
      tsk_pkg::TSK_ST_DAYS_OUT: phase_last = `TSK_DAYS_LAST;
      tsk_pkg::TSK_ST_DAYS_IN: phase_last = `TSK_DAYS_LAST;
      tsk_pkg::TSK_ST_DONE: phase_next = tsk_pkg::TSK_ST_DONE;
    endcase
  end

  // transfer sequencer, bit counter advances on serial clock rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= tsk_pkg::TSK_ST_IDLE;
      cnt_reg <= '0;
    end else if (!link_rst_s) begin
      state_reg <= tsk_pkg::TSK_ST_IDLE;
      cnt_reg <= '0;
    end else if (state_reg == tsk_pkg::TSK_ST_IDLE) begin
      state_reg <= phase_next;
      cnt_reg <= '0;
    end else if (sclk_rise && state_reg != tsk_pkg::TSK_ST_DONE) begin
      if (cnt_reg == phase_last) begin
        state_reg <= phase_next;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + `TSK_CNT_ONE;
      end
    end
  end

  // command shift register and transfer direction
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= '0;
      is_write_reg <= 1'b0;
    end else if (sclk_rise && state_reg == tsk_pkg::TSK_ST_CMD) begin
      cmd_reg <= cmd_next;
      if (cmd_done) begin
        is_write_reg <= norm_hit(cmd_next, `TSK_FN_NWRITE);
      end
    end
  end

  // compare register for the security match
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_reg <= '0;
    end else if (sclk_rise && state_reg == tsk_pkg::TSK_ST_MATCH_IN) begin
      cmp_reg <= {dq_s, cmp_reg[`TSK_ID_W-1:1]};
    end
  end

  // identification, match and secure memories
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      id_reg <= '0;
      match_reg <= '0;
      secure_reg <= '0;
    end else if (cmd_done && prog_hit(cmd_next, `TSK_FN_PID) && !expired_reg) begin
      id_reg <= '0;
      match_reg <= '0;
      secure_reg <= '0;
    end else if (sclk_rise && state_reg == tsk_pkg::TSK_ST_PID_IN) begin
      if (cnt_reg[`TSK_PID_SEL]) begin
        match_reg[cnt_reg[5:0]] <= dq_s;
      end else begin
        id_reg[cnt_reg[5:0]] <= dq_s;
      end
    end else if (sclk_rise && state_reg == tsk_pkg::TSK_ST_MEM_IN) begin
      secure_reg[cnt_reg] <= dq_s;
    end
  end

  // days remaining and expiry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      days_reg <= `TSK_DAYS_RST;
      days_sh_reg <= '0;
      expired_reg <= 1'b0;
    end else if (sclk_rise && state_reg == tsk_pkg::TSK_ST_DAYS_IN) begin
      days_sh_reg <= {dq_s, days_sh_reg[`TSK_DAYS_W-1:1]};
      if (cnt_reg == `TSK_DAYS_LAST) begin
        days_reg <= {dq_s, days_sh_reg[`TSK_DAYS_W-1:1]};
      end
    end else if (day_wrap && !expired_reg) begin
      if (days_reg == '0) begin
        expired_reg <= 1'b1;
      end else begin
        days_reg <= days_reg - `TSK_DAYS_W'(1);
      end
    end
  end

  // lock, arm and oscillator run bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= 1'b0;
      arm_reg <= 1'b0;
      osc_run_reg <= 1'b0;
    end else if (cmd_done) begin
      if (prog_hit(cmd_next, `TSK_FN_LOCK)) begin
        lock_reg <= 1'b1;
      end
      if (prog_hit(cmd_next, `TSK_FN_ARM)) begin
        arm_reg <= 1'b1;
      end else if (prog_hit(cmd_next, `TSK_FN_STOP) && !lock_reg) begin
        arm_reg <= 1'b0;
        osc_run_reg <= 1'b0;
      end else if (cmd_ok(cmd_next) && arm_reg) begin
        osc_run_reg <= 1'b1;
      end
    end
  end

  // day clock snapshot taken when any command word completes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_snap_reg <= '0;
    end else if (cmd_done) begin
      clk_snap_reg <= day_cnt;
    end
  end

  // free-running pseudo-random source for garbled output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_reg <= `TSK_LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  // output bit selection
  always_comb begin
    out_phase = 1'b1;
    out_bit = 1'b0;
    unique case (state_reg)
      tsk_pkg::TSK_ST_ID_OUT: out_bit = id_reg[cnt_reg[5:0]];
      tsk_pkg::TSK_ST_MEM_OUT: out_bit = secure_reg[cnt_reg];
      tsk_pkg::TSK_ST_GARBLE: out_bit = lfsr_reg[0];
      tsk_pkg::TSK_ST_CLK_OUT: out_bit = clk_snap_reg[cnt_reg[4:0]];
      tsk_pkg::TSK_ST_DAYS_OUT: out_bit = days_rd[cnt_reg[3:0]];
      tsk_pkg::TSK_ST_IDLE, tsk_pkg::TSK_ST_CMD, tsk_pkg::TSK_ST_MATCH_IN,
      tsk_pkg::TSK_ST_MEM_IN, tsk_pkg::TSK_ST_PID_IN, tsk_pkg::TSK_ST_DAYS_IN,
      tsk_pkg::TSK_ST_DONE: out_phase = 1'b0;
    endcase
  end

  // data line driver: drive on fall, release on rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out_reg <= 1'b0;
      dq_oe_reg <= 1'b0;
    end else if (!link_rst_s) begin
      dq_oe_reg <= 1'b0;
    end else if (sclk_rise) begin
      dq_oe_reg <= 1'b0;
    end else if (sclk_fall && out_phase) begin
      dq_out_reg <= out_bit;
      dq_oe_reg <= 1'b1;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe = dq_oe_reg;
  assign days_expired = expired_reg;
  assign days_locked = lock_reg;
  assign osc_armed = arm_reg;
  assign osc_running = osc_run_reg;

endmodule

// [tsk_defines.svh]
// constants for the timed secure key serial block
`ifndef TSK_DEFINES_SVH
`define TSK_DEFINES_SVH

// pin positions in the synchronised pin vector
`define TSK_PIN_RST 0
`define TSK_PIN_SCLK 1
`define TSK_PIN_DQ 2
`define TSK_PIN_W 3

// command word fields, bits shifted in least significant first
`define TSK_CMD_W 24
`define TSK_FN_HI 7
`define TSK_FN_LO 0
`define TSK_MODE_HI 9
`define TSK_MODE_LO 8
`define TSK_PAD_HI 19
`define TSK_PAD_LO 10
`define TSK_TAIL_HI 23
`define TSK_TAIL_LO 20
`define TSK_MODE_NORM 2'h1
`define TSK_MODE_PROG 2'h2
`define TSK_PAD_VAL 10'h000
`define TSK_TAIL_VAL 4'hb

// function codes
`define TSK_FN_NREAD 8'h62
`define TSK_FN_NWRITE 8'h9d
`define TSK_FN_PID 8'h9d
`define TSK_FN_RDCLK 8'hf1
`define TSK_FN_WRDAYS 8'hf2
`define TSK_FN_RDDAYS 8'hf3
`define TSK_FN_STOP 8'hf4
`define TSK_FN_ARM 8'hf5
`define TSK_FN_LOCK 8'hf6

// memory sizes and last bit index of each phase
`define TSK_ID_W 64
`define TSK_MEM_W 384
`define TSK_CLK_W 20
`define TSK_DAYS_W 9
`define TSK_CNT_W 9
`define TSK_CMD_LAST 9'h017
`define TSK_ID_LAST 9'h03f
`define TSK_MEM_LAST 9'h17f
`define TSK_PID_LAST 9'h07f
`define TSK_CLK_LAST 9'h013
`define TSK_DAYS_LAST 9'h008
`define TSK_CNT_ONE 9'h001
`define TSK_PID_SEL 6

// reset values and the expired days readout
`define TSK_DAYS_RST 9'h000
`define TSK_DAYS_EXPIRED 9'h1ff
`define TSK_LFSR_SEED 16'hace1

// day clock oscillator
`define TSK_OSC_PERIOD_US 82400
`define TSK_CLK_MHZ 20
`define TSK_OSC_CYCLES (`TSK_OSC_PERIOD_US * `TSK_CLK_MHZ)
`define TSK_PRESC_W 21

`endif

// [tsk_pkg.sv]
// types of the timed secure key serial block
package tsk_pkg;

  typedef enum logic [11:0] {
    TSK_ST_IDLE     = 12'h001,
    TSK_ST_CMD      = 12'h002,
    TSK_ST_ID_OUT   = 12'h004,
    TSK_ST_MATCH_IN = 12'h008,
    TSK_ST_MEM_OUT  = 12'h010,
    TSK_ST_MEM_IN   = 12'h020,
    TSK_ST_GARBLE   = 12'h040,
    TSK_ST_PID_IN   = 12'h080,
    TSK_ST_CLK_OUT  = 12'h100,
    TSK_ST_DAYS_OUT = 12'h200,
    TSK_ST_DAYS_IN  = 12'h400,
    TSK_ST_DONE     = 12'h800
  } tsk_state_t;

endpackage

// [tsk_pin_sync.sv]
// two-stage pin synchronisers and serial clock edge detection
`include "tsk_defines.svh"

module tsk_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // raw pins
  input wire logic [`TSK_PIN_W-1:0] pins_in,
  // synchronised pins and edges
  output logic [`TSK_PIN_W-1:0] pins_sync,
  output logic sclk_rise,
  output logic sclk_fall
);

  logic [`TSK_PIN_W-1:0] stage1_reg;
  logic [`TSK_PIN_W-1:0] stage2_reg;
  logic sclk_prev_reg;

  genvar g;
  generate
    for (g = 0; g < `TSK_PIN_W; g++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          stage1_reg[g] <= 1'b0;
          stage2_reg[g] <= 1'b0;
        end else begin
          stage1_reg[g] <= pins_in[g];
          stage2_reg[g] <= stage1_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= stage2_reg[`TSK_PIN_SCLK];
    end
  end

  assign pins_sync = stage2_reg;
  assign sclk_rise = stage2_reg[`TSK_PIN_SCLK] & ~sclk_prev_reg;
  assign sclk_fall = ~stage2_reg[`TSK_PIN_SCLK] & sclk_prev_reg;

endmodule

// [tsk_day_clock.sv]
// internal oscillator prescaler and 20-bit day clock counter
`include "tsk_defines.svh"

module tsk_day_clock #(
  parameter int unsigned TICK_CYCLES = `TSK_OSC_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic run,
  // day clock state
  output logic [`TSK_CLK_W-1:0] count,
  output logic wrap
);

  localparam logic [`TSK_PRESC_W-1:0] TICK_LAST = `TSK_PRESC_W'(TICK_CYCLES - 1);

  logic [`TSK_PRESC_W-1:0] presc_reg;
  logic [`TSK_CLK_W-1:0] count_reg;
  logic tick;

  assign tick = run && (presc_reg == TICK_LAST);

  // oscillator period as a prescaled tick
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_reg <= '0;
    end else if (!run || tick) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + `TSK_PRESC_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (tick) begin
      count_reg <= count_reg + `TSK_CLK_W'(1);
    end
  end

  assign count = count_reg;
  assign wrap = tick && (count_reg == '1);

endmodule

// [tsk_key_properties.sv]
// concurrent checks on the timed secure key ports
module tsk_key_properties #(
  parameter int unsigned OSC_TICK_CYCLES = 1648000
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link pins
  input wire logic link_rst_pin,
  input wire logic link_sclk_pin,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  // status
  input wire logic days_expired,
  input wire logic days_locked,
  input wire logic osc_armed,
  input wire logic osc_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_drive_on_fall: assert property (
    $rose(dq_oe) |-> !$past(link_sclk_pin, 2)) else $error("line driven outside clock low");
  a_release_on_rise: assert property (
    $fell(dq_oe) |-> link_sclk_pin || !link_rst_pin) else $error("line released early");
  a_bit_held: assert property (
    dq_oe && $past(dq_oe) |-> $stable(dq_out)) else $error("output bit changed while driven");
  a_abort_release: assert property (
    !link_rst_pin [*6] |-> !dq_oe) else $error("line still driven after link reset");
  a_drive_needs_rst: assert property (
    dq_oe |-> $past(link_rst_pin, 5)) else $error("line driven without link reset high");
  a_lock_sticky: assert property (
    days_locked |=> days_locked) else $error("lock flag dropped");
  a_expiry_sticky: assert property (
    days_expired |=> days_expired) else $error("expiry flag dropped");
  a_arm_kept_locked: assert property (
    days_locked && osc_armed |=> osc_armed) else $error("arm cleared after lock");
  a_run_needs_arm: assert property (
    $rose(osc_running) |-> osc_armed) else $error("oscillator started unarmed");
  a_arm_in_frame: assert property (
    $rose(osc_armed) |-> $past(link_rst_pin, 4)) else $error("arm set outside a transfer");
  c_locked: cover property ($rose(days_locked));
  c_running: cover property ($rose(osc_running));
  c_disarmed: cover property ($fell(osc_armed));
endmodule

// [tsk_host_model.sv]
// host side of the three-wire link: reset, serial clock and data
module tsk_host_model (
  // clock
  input wire logic clk,
  // link pins
  output logic link_rst_pin,
  output logic link_sclk_pin,
  output logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  // received bit report
  output logic rx_valid,
  output logic [1:0] rx_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic h_oe;
  logic h_d;
  // wire level: device, else host, else pulled down
  assign dq_in = dq_oe ? dq_out : (h_oe ? h_d : 1'b0);
  initial begin
    link_rst_pin = 1'b0;
    link_sclk_pin = 1'b0;
    h_oe = 1'b0;
    h_d = 1'b0;
    rx_valid = 1'b0;
    rx_val = 2'h0;
  end
  task automatic open_link();
    @(posedge clk);
    link_rst_pin <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // drop link reset first, park the clock low later
  task automatic close_link();
    @(posedge clk);
    link_rst_pin <= 1'b0;
    h_oe <= 1'b0;
    repeat (4) @(posedge clk);
    link_sclk_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // fall, then drop link reset while the device still drives the line
  task automatic cut_link();
    @(posedge clk);
    link_sclk_pin <= 1'b0;
    h_oe <= 1'b0;
    repeat (5) @(posedge clk);
    link_rst_pin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // one 8-cycle clock: data set at fall, taken at rise, output read after rise
  task automatic xbit(input logic drv, input logic b, output logic [1:0] r);
    @(posedge clk);
    link_sclk_pin <= 1'b0;
    h_oe <= drv;
    h_d <= b;
    repeat (4) @(posedge clk);
    link_sclk_pin <= 1'b1;
    @(posedge clk);
    #1 r = {dq_oe, dq_in};
    rx_valid <= !drv;
    rx_val <= r;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// [tb_top.sv]
// self-checking bench for the timed secure key
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICKS = 4;
  logic clk, sys_rst, link_rst_pin, link_sclk_pin, dq_in, dq_out, dq_oe;
  logic days_expired, days_locked, osc_armed, osc_running, rx_valid, skip;
  logic [1:0] rx_val;
  logic [63:0] id, mt;
  logic [383:0] mem, got;
  logic [19:0] c1, c2;
  logic [8:0] d1, d2;
  logic [1:0] exp_q[$];
  logic [23:0] bad[5] = '{24'hb001f1, 24'hb00262, 24'hb00062, 24'hb00362, 24'ha00162};
  int n_mismatch = 0;
  int checked = 0;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  tsk_key #(.OSC_TICK_CYCLES(TICKS)) tsk_key_inst (.clk(clk), .sys_rst(sys_rst),
    .link_rst_pin(link_rst_pin), .link_sclk_pin(link_sclk_pin), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .days_expired(days_expired),
    .days_locked(days_locked), .osc_armed(osc_armed), .osc_running(osc_running));
  tsk_host_model tsk_host_model_inst (.clk(clk), .link_rst_pin(link_rst_pin),
    .link_sclk_pin(link_sclk_pin), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .rx_valid(rx_valid), .rx_val(rx_val));
  task automatic chk(input logic [383:0] a, input logic [383:0] e);
    checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  always @(posedge clk) begin
    if (rx_valid && !skip) begin
      chk(384'(rx_val), exp_q.size() ? 384'(exp_q.pop_front()) : 384'h4);
    end
  end
  task automatic xfer(input logic drv, input logic [383:0] v, input int n);
    logic [1:0] r;
    for (int i = 0; i < n; i++) begin
      tsk_host_model_inst.xbit(drv, v[i], r);
      got[i] = r[0];
    end
  endtask
  task automatic note(input logic oe, input logic [383:0] v, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back({oe, v[i] & oe});
  endtask
  task automatic cmd(input logic [23:0] w);
    tsk_host_model_inst.open_link();
    xfer(1'b1, 384'(w), $bits(w));
  endtask
  task automatic close();
    tsk_host_model_inst.close_link();
  endtask
  task automatic bare(input logic [23:0] w);
    cmd(w);
    close();
  endtask
  task automatic pid();
    id = {$urandom, $urandom};
    mt = {$urandom, $urandom};
    cmd(24'hb0029d);
    xfer(1'b1, 384'({mt, id}), $bits({mt, id}));
    close();
  endtask
  task automatic nread(input logic [63:0] m, input logic ok);
    cmd(24'hb00162);
    note(1'b1, 384'(id), $bits(id));
    xfer(1'b0, '0, $bits(id));
    xfer(1'b1, 384'(m), $bits(m));
    skip = !ok;
    if (ok) note(1'b1, mem, $bits(mem));
    xfer(1'b0, '0, $bits(mem));
    close();
    skip = 1'b0;
  endtask
  task automatic nwrite(input logic [63:0] m, input logic [383:0] d);
    cmd(24'hb0019d);
    note(1'b1, 384'(id), $bits(id));
    xfer(1'b0, '0, $bits(id));
    xfer(1'b1, 384'(m), $bits(m));
    xfer(1'b1, d, $bits(d));
    close();
  endtask
  task automatic wdays(input logic [8:0] v);
    cmd(24'hb002f2);
    xfer(1'b1, 384'(v), $bits(v));
    close();
  endtask
  task automatic rdays(input logic [8:0] e);
    cmd(24'hb002f3);
    note(1'b1, 384'(e), $bits(e));
    xfer(1'b0, '0, $bits(e));
    close();
  endtask
  task automatic rclk(output logic [19:0] v);
    cmd(24'hb002f1);
    skip = 1'b1;
    xfer(1'b0, '0, $bits(v));
    v = got[19:0];
    close();
    skip = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    skip = 1'b0;
    void'($urandom(32'h0c37b711));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({days_expired, days_locked, osc_armed, osc_running}, 4'h0);
    pid();
    for (int i = 0; i < 12; i++) mem[i*32 +: 32] = $urandom;
    nwrite(mt, mem);
    nread(mt, 1'b1);
    nread(~mt, 1'b0);
    chk(got !== mem, 1'b1);
    nwrite(~mt, ~mem);
    nread(mt, 1'b1);
    pid();
    mem = '0;
    nread(mt, 1'b1);
    cmd(24'hb00162);
    note(1'b1, 384'(id), 3);
    xfer(1'b0, '0, 3);
    tsk_host_model_inst.cut_link();
    chk(dq_oe, 1'b0);
    foreach (bad[i]) begin
      cmd(bad[i]);
      note(1'b0, '0, 8);
      xfer(1'b0, '0, 8);
      close();
    end
    rclk(c1);
    chk(c1, 20'h0);
    d1 = 9'($urandom);
    d2 = ~d1;
    wdays(d1);
    rdays(d1);
    wdays(d2);
    rdays(d2);
    bare(24'hb002f5);
    chk({osc_armed, osc_running}, 2'h2);
    bare(24'hb002f4);
    chk(osc_armed, 1'b0);
    bare(24'hb002f6);
    chk({days_locked, osc_running}, 2'h2);
    wdays(d1);
    rdays(d2);
    bare(24'hb002f5);
    chk({osc_armed, osc_running}, 2'h2);
    bare(24'hb002f4);
    chk({osc_armed, osc_running}, 2'h3);
    rdays(d2);
    chk(osc_running, 1'b1);
    rclk(c1);
    rclk(c2);
    chk(c2 > c1, 1'b1);
    chk(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule
bind tsk_key tsk_key_properties #(.OSC_TICK_CYCLES(OSC_TICK_CYCLES)) tsk_key_properties_inst (
  .clk(clk), .sys_rst(sys_rst), .link_rst_pin(link_rst_pin),
  .link_sclk_pin(link_sclk_pin), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .days_expired(days_expired), .days_locked(days_locked), .osc_armed(osc_armed),
  .osc_running(osc_running));
